// ### include/adcsf_defines.svh
// Constants of the converter status-flag block: register map, field positions, sizes.
// Assumes a byte-addressed register bus with word-aligned accesses; all seven low address bits are decoded, but channel result reads ignore the low two.
`ifndef ADCSF_DEFINES_SVH
`define ADCSF_DEFINES_SVH

// ****************************************
// Sizes
// ****************************************
`define ADCSF_NCH 8
`define ADCSF_CHW 3
`define ADCSF_DW 10
`define ADCSF_AW 7

// ****************************************
// Register byte offsets
// ****************************************
`define ADCSF_OFF_CTRL 7'h00
`define ADCSF_OFF_MODE 7'h04
`define ADCSF_OFF_CH_ENA 7'h08
`define ADCSF_OFF_CH_DIS 7'h0c
`define ADCSF_OFF_CH_STAT 7'h10
`define ADCSF_OFF_STATUS 7'h1c
`define ADCSF_OFF_LAST 7'h20
`define ADCSF_OFF_CHAN0 7'h30
`define ADCSF_OFF_CHAN_LAST 7'h4c

// ****************************************
// Field positions
// ****************************************
`define ADCSF_CTRL_START 0
`define ADCSF_MODE_SLEEP 0
`define ADCSF_ST_EOC_LSB 0
`define ADCSF_ST_CHAN_OVR_LSB 8
`define ADCSF_ST_DATA_READY 16
`define ADCSF_ST_GLOBAL_OVR 17
`define ADCSF_ST_LOWPWR 18
`define ADCSF_LAST_CH_LSB 12

// ****************************************
// Bus encodings and reset values
// ****************************************
`define ADCSF_HTRANS_NONSEQ_BIT 1
`define ADCSF_HREADY_RST 1'b1
`define ADCSF_HRESP_OKAY 1'b0

`endif

// ### include/adcsf_pkg.sv
// Types shared by the converter status-flag block.
// Assumes adcsf_defines.svh is on the include path.
`include "adcsf_defines.svh"

package adcsf_pkg;

	typedef logic [`ADCSF_NCH-1:0] adcsf_mask_t;
	typedef logic [`ADCSF_CHW-1:0] adcsf_chan_t;
	typedef logic [`ADCSF_DW-1:0] adcsf_data_t;
	typedef logic [`ADCSF_AW-1:0] adcsf_addr_t;

	// Whole state of the top module, apart from the per-channel flag cells
	typedef struct packed {
		logic pend;
		logic pwrite;
		adcsf_addr_t paddr;
		logic hreadyout;
		logic hresp;
		logic [31:0] hrdata;
		logic sleep_sel;
		adcsf_mask_t chen;
		logic start;
		logic low_power;
		logic data_ready_flag;
		logic global_overrun_flag;
		adcsf_data_t last_data;
		adcsf_chan_t last_ch;
		logic [`ADCSF_NCH-1:0][`ADCSF_DW-1:0] chan_data;
	} adcsf_state_t;

	// Per-channel flag pair
	typedef struct packed {
		logic eoc;
		logic ovr;
	} adcsf_flag_t;

endpackage : adcsf_pkg

// ### rtl/adcsf_chan_flag.sv
// One channel's conversion-done and overrun flags.
// Assumes set and clear strobes are one-cycle pulses on hclk.
`timescale 1ns/1ps

module adcsf_chan_flag
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic set_done,
	input wire logic clr_done,
	input wire logic clr_ovr,
	output logic done,
	output logic ovr
);
	import adcsf_pkg::*;

	adcsf_flag_t f_reg;
	adcsf_flag_t f_next;

	always_comb
	begin
		f_next = f_reg;
		// Set beats a coincident read clear
		f_next.eoc = set_done | (f_reg.eoc & ~clr_done);
		// Overrun: new result while previous one still unread
		// A new overrun, done set again while still set, beats a coincident status read clear
		f_next.ovr = (set_done & f_reg.eoc) | (f_reg.ovr & ~clr_ovr);
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			f_reg <= '0;
		else
			f_reg <= f_next;
	end

	assign done = f_reg.eoc;
	assign ovr = f_reg.ovr;

endmodule : adcsf_chan_flag

// ### rtl/adcsf_top.sv
// Converter status-flag logic: AHB-Lite register slave, result storage and flags.
// Assumes the conversion core runs on hclk and pulses conv_end for one cycle per result.
//
// Function
// - Data-ready clears only on a last-result read, never on a channel result read.
// - An end of conversion on an enabled channel stores both results and raises data-ready.
// - A last-result read together with an end of conversion keeps data-ready only if data was stored.
// - A channel result read together with a new result never blocks data-ready.
// - Overall overrun rises when a result ends while data-ready is set, even during a status read.
// - A status read clears overall overrun unless a new overrun happens in that cycle.
// - A channel result read with a new result, data-ready set, still sets overall overrun.
// - A channel overrun rises when its result ends while its done flag is still set.
// - A channel done flag clears on a read of its result or of the last result.
// - A status read clears channel overrun unless a new channel overrun happens in that cycle.
// - A channel disabled during its conversion never raises its done flag.
// - A channel result read clears only that channel's done flag.
// - Sleep chosen while idle takes effect only after the next conversion ends.
`timescale 1ns/1ps

module adcsf_top
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic conv_end,
	input wire adcsf_pkg::adcsf_chan_t conv_chan,
	input wire adcsf_pkg::adcsf_data_t conv_result,
	output logic conv_start,
	output adcsf_pkg::adcsf_mask_t chan_enable,
	output logic low_power
);
	import adcsf_pkg::*;

	// ****************************************
	// Address decoding helpers
	// ****************************************
	function automatic logic is_chan_addr(input adcsf_addr_t a);
		is_chan_addr = (a >= `ADCSF_OFF_CHAN0) && (a <= `ADCSF_OFF_CHAN_LAST);
	endfunction : is_chan_addr

	function automatic adcsf_chan_t chan_of(input adcsf_addr_t a);
		adcsf_addr_t d;
		d = a - `ADCSF_OFF_CHAN0;
		chan_of = d[`ADCSF_CHW+1:2];
	endfunction : chan_of

	// ****************************************
	// State and flag cells
	// ****************************************
	adcsf_state_t s_reg;
	adcsf_state_t s_next;

	adcsf_mask_t eoc;
	adcsf_mask_t chan_ovr;
	adcsf_mask_t eoc_set;
	adcsf_mask_t eoc_clr;

	logic rd_cycle;
	logic wr_cycle;
	logic rd_last;
	logic rd_status;
	logic rd_chan;
	adcsf_chan_t rd_idx;
	logic store;

	always_comb
	begin
		rd_cycle = s_reg.pend & ~s_reg.pwrite;
		wr_cycle = s_reg.pend & s_reg.pwrite;
		rd_last = rd_cycle && (s_reg.paddr == `ADCSF_OFF_LAST);
		rd_status = rd_cycle && (s_reg.paddr == `ADCSF_OFF_STATUS);
		rd_chan = rd_cycle && is_chan_addr(s_reg.paddr);
		rd_idx = chan_of(s_reg.paddr);
		// Enable is sampled as the result lands, so a channel switched off
		// mid-conversion loses its result instead of raising a stale flag
		store = conv_end & s_reg.chen[conv_chan];
	end

	genvar gi;
	generate
		for (gi = 0; gi < `ADCSF_NCH; gi++)
		begin : g_chan
			// Each channel decodes only its own index, so a channel result read never clears a neighbour
			assign eoc_set[gi] = store && (conv_chan == adcsf_chan_t'(gi));
			assign eoc_clr[gi] = rd_last | (rd_chan && (rd_idx == adcsf_chan_t'(gi)));

			adcsf_chan_flag u_flag
			(
				.hclk(hclk),
				.hresetn(hresetn),
				.set_done(eoc_set[gi]),
				.clr_done(eoc_clr[gi]),
				.clr_ovr(rd_status),
				.done(eoc[gi]),
				.ovr(chan_ovr[gi])
			);
		end
	endgenerate

	// ****************************************
	// Next-state logic
	// ****************************************
	always_comb
	begin
		s_next = s_reg;
		s_next.start = 1'b0;

		// Bus data phase: one wait state so read data comes from a flop
		if (s_reg.pend)
		begin
			s_next.pend = 1'b0;
			s_next.hreadyout = 1'b1;
		end
		if (s_reg.hreadyout && hready && hsel && htrans[`ADCSF_HTRANS_NONSEQ_BIT])
		begin
			s_next.pend = 1'b1;
			s_next.pwrite = hwrite;
			s_next.paddr = haddr[`ADCSF_AW-1:0];
			s_next.hreadyout = 1'b0;
		end

		// Read mux, values as they stand before this cycle's updates
		if (rd_cycle)
		begin
			s_next.hrdata = '0;
			if (s_reg.paddr == `ADCSF_OFF_MODE)
			begin
				s_next.hrdata[`ADCSF_MODE_SLEEP] = s_reg.sleep_sel;
			end
			else if (s_reg.paddr == `ADCSF_OFF_CH_STAT)
			begin
				s_next.hrdata[`ADCSF_NCH-1:0] = s_reg.chen;
			end
			else if (s_reg.paddr == `ADCSF_OFF_STATUS)
			begin
				s_next.hrdata[`ADCSF_ST_EOC_LSB +: `ADCSF_NCH] = eoc;
				s_next.hrdata[`ADCSF_ST_CHAN_OVR_LSB +: `ADCSF_NCH] = chan_ovr;
				s_next.hrdata[`ADCSF_ST_DATA_READY] = s_reg.data_ready_flag;
				s_next.hrdata[`ADCSF_ST_GLOBAL_OVR] = s_reg.global_overrun_flag;
				s_next.hrdata[`ADCSF_ST_LOWPWR] = s_reg.low_power;
			end
			else if (s_reg.paddr == `ADCSF_OFF_LAST)
			begin
				s_next.hrdata[`ADCSF_DW-1:0] = s_reg.last_data;
				s_next.hrdata[`ADCSF_LAST_CH_LSB +: `ADCSF_CHW] = s_reg.last_ch;
			end
			else if (is_chan_addr(s_reg.paddr))
			begin
				s_next.hrdata[`ADCSF_DW-1:0] = s_reg.chan_data[rd_idx];
			end
		end

		// Register writes; unmapped and read-only offsets ignore data
		if (wr_cycle)
		begin
			if (s_reg.paddr == `ADCSF_OFF_CTRL)
			begin
				s_next.start = hwdata[`ADCSF_CTRL_START];
			end
			else if (s_reg.paddr == `ADCSF_OFF_MODE)
			begin
				s_next.sleep_sel = hwdata[`ADCSF_MODE_SLEEP];
			end
			else if (s_reg.paddr == `ADCSF_OFF_CH_ENA)
			begin
				s_next.chen = s_reg.chen | hwdata[`ADCSF_NCH-1:0];
			end
			else if (s_reg.paddr == `ADCSF_OFF_CH_DIS)
			begin
				s_next.chen = s_reg.chen & ~hwdata[`ADCSF_NCH-1:0];
			end
		end

		// Result storage is independent of any disable in the same cycle
		if (store)
		begin
			s_next.chan_data[conv_chan] = conv_result;
			s_next.last_data = conv_result;
			s_next.last_ch = conv_chan;
		end

		// Data-ready: only a last-result read clears it and a stored result wins
		s_next.data_ready_flag = store | (s_reg.data_ready_flag & ~rd_last);

		// Overall overrun is always re-evaluated, status read or not
		s_next.global_overrun_flag = (store & s_reg.data_ready_flag)
			| (s_reg.global_overrun_flag & ~rd_status);

		// Sleep is deferred to the end of a conversion; a start wakes the core
		// for that conversion and sleep follows when it ends
		if (!s_reg.sleep_sel)
		begin
			s_next.low_power = 1'b0;
		end
		else if (conv_end)
		begin
			s_next.low_power = 1'b1;
		end
		else if (s_next.start)
		begin
			s_next.low_power = 1'b0;
		end
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			s_reg <= '0;
			s_reg.hreadyout <= `ADCSF_HREADY_RST;
			s_reg.hresp <= `ADCSF_HRESP_OKAY;
		end
		else
		begin
			s_reg <= s_next;
		end
	end

	assign hreadyout = s_reg.hreadyout;
	assign hresp = s_reg.hresp;
	assign hrdata = s_reg.hrdata;
	assign conv_start = s_reg.start;
	assign chan_enable = s_reg.chen;
	assign low_power = s_reg.low_power;

endmodule : adcsf_top

// ### testbench/adcsf_core_model.sv
// Conversion core model: ends a conversion on command or some cycles after a start pulse.
// Assumes the bench raises fire for one cycle; conv_end follows one edge later.
`timescale 1ns/1ps

module adcsf_core_model
#(
	parameter int LAT = 4,
	parameter int START_CH = 1
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic conv_start,
	input wire logic fire,
	input wire adcsf_pkg::adcsf_chan_t fire_chan,
	input wire adcsf_pkg::adcsf_data_t fire_data,
	output logic conv_end,
	output adcsf_pkg::adcsf_chan_t conv_chan,
	output adcsf_pkg::adcsf_data_t conv_result
);
	import adcsf_pkg::*;
	logic [3:0] cnt;
	logic fin;
	assign fin = (cnt == 4'h1);
	// Outside an end pulse channel and data toggle, so stale values never look valid
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cnt <= 4'h0;
			conv_end <= 1'b0;
			conv_chan <= '0;
			conv_result <= '0;
		end
		else
		begin
			cnt <= conv_start ? 4'(LAT) : (cnt != 4'h0) ? cnt - 4'h1 : cnt;
			conv_end <= fire || fin;
			conv_chan <= fire ? fire_chan : fin ? adcsf_chan_t'(START_CH) : ~conv_chan;
			conv_result <= fire ? fire_data : fin ? 10'h123 : ~conv_result;
		end
	end
endmodule : adcsf_core_model

// ### testbench/adcsf_top_properties.sv
// Checker of the status-flag block, watching only its top-level ports.
// Assumes a single AHB-Lite slave, so hready equals hreadyout.
`timescale 1ns/1ps
`include "adcsf_defines.svh"

module adcsf_top_checker
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic conv_end,
	input wire adcsf_pkg::adcsf_chan_t conv_chan,
	input wire logic conv_start,
	input wire adcsf_pkg::adcsf_mask_t chan_enable,
	input wire logic low_power
);
	import adcsf_pkg::*;
	logic tk, sv, rd_p, wr_p, ready_m, gl_ovr_m;
	logic [6:0] pa;
	assign tk = hsel && htrans[1] && hready && hreadyout;
	assign sv = conv_end && chan_enable[conv_chan];
	// Reference flags: a new result beats a last-result read, a new overrun beats a status read
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			rd_p <= 1'b0;
			wr_p <= 1'b0;
			pa <= 7'h00;
			ready_m <= 1'b0;
			gl_ovr_m <= 1'b0;
		end
		else
		begin
			rd_p <= tk && !hwrite;
			wr_p <= tk && hwrite;
			pa <= tk ? haddr[6:0] : pa;
			ready_m <= sv ? 1'b1 : (rd_p && pa == `ADCSF_OFF_LAST) ? 1'b0 : ready_m;
			gl_ovr_m <= (sv && ready_m) ? 1'b1 : (rd_p && pa == `ADCSF_OFF_STATUS) ? 1'b0 : gl_ovr_m;
		end
	end
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	AST_OKAY: assert property (hresp == `ADCSF_HRESP_OKAY) else $error("hresp not OKAY");
	AST_WAIT: assert property (tk |=> !hreadyout ##1 hreadyout) else $error("bad wait state");
	AST_START: assert property ($rose(conv_start) |-> $past(wr_p) ##1 !conv_start)
		else $error("stray start pulse");
	AST_ENA: assert property ($changed(chan_enable) |-> $past(wr_p)) else $error("enable moved");
	AST_RDATA: assert property ($changed(hrdata) |-> $past(rd_p)) else $error("hrdata moved");
	AST_LP_RISE: assert property ($rose(low_power) |-> $past(conv_end)) else $error("early sleep");
	// A start write drops sleep one edge after the write, a sleep deselect one edge later
	AST_LP_FALL: assert property ($fell(low_power) |-> $past(wr_p) || $past(wr_p, 2))
		else $error("sleep dropped");
	AST_DATA_READY: assert property (rd_p && pa == `ADCSF_OFF_STATUS |=> hrdata[`ADCSF_ST_DATA_READY] == $past(ready_m))
		else $error("data ready flag wrong");
	AST_GLOBAL_OVR: assert property (rd_p && pa == `ADCSF_OFF_STATUS |=> hrdata[`ADCSF_ST_GLOBAL_OVR] == $past(gl_ovr_m))
		else $error("overall overrun flag wrong");
	COV_RD_EOC: cover property (rd_p && conv_end);
	COV_SLEEP: cover property ($rose(low_power));
	COV_WRITE: cover property (tk && hwrite);
endmodule : adcsf_top_checker

bind adcsf_top adcsf_top_checker u_adcsf_top_checker (.hclk, .hresetn, .hsel, .haddr, .htrans,
	.hwrite, .hready, .hreadyout, .hresp, .hrdata, .conv_end, .conv_chan, .conv_start,
	.chan_enable, .low_power);

// ### testbench/adcsf_top_tb.sv
// Bench: AHB-Lite reads and writes of the status-flag block with results from the core model.
// Assumes the core model answers one edge after fire, so results can meet a read's data phase.
`timescale 1ns/1ps
`include "adcsf_defines.svh"

module adcsf_top_tb;
	import adcsf_pkg::*;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, fire = 0;
	logic [31:0] haddr = '0, hwdata = '0, hrdata;
	logic [1:0] htrans = '0;
	logic hready, hresp, conv_end, conv_start, low_power;
	adcsf_chan_t conv_chan, fc = '0;
	adcsf_data_t conv_result, fd = '0;
	adcsf_mask_t chan_enable;
	bit pend_fire;
	int mismatches = 0, n_tests = 0, cyc = 0;
	localparam logic [6:0] ST = `ADCSF_OFF_STATUS, LA = `ADCSF_OFF_LAST, C0 = `ADCSF_OFF_CHAN0;
	adcsf_top u_adcsf_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010),
		.hwdata, .hready, .hreadyout(hready), .hresp, .hrdata, .conv_end, .conv_chan,
		.conv_result, .conv_start, .chan_enable, .low_power);
	adcsf_core_model u_adcsf_core_model (.hclk, .hresetn, .conv_start, .fire, .fire_chan(fc),
		.fire_data(fd), .conv_end, .conv_chan, .conv_result);
	initial forever #2 hclk = ~hclk;
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_of_test
	always @(posedge hclk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			mismatches++;
			end_of_test();
		end
	end
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e)
		begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	// An armed result ends in the data phase, at the edge where read side effects land
	task automatic xfer(input logic w, input logic [6:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {25'h0, a};
		hwrite <= w;
		fire <= pend_fire;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= d;
		fire <= 1'b0;
		pend_fire = 0;
		do @(posedge hclk); while (hready !== 1'b1);
		q = hrdata;
	endtask : xfer
	task automatic rd(input logic [6:0] a, input logic [31:0] e);
		logic [31:0] q;
		xfer(1'b0, a, 32'h0, q);
		chk($sformatf("reg %h", a), q, e);
	endtask : rd
	task automatic wr(input logic [6:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask : wr
	task automatic ev(input adcsf_chan_t c, input adcsf_data_t d, input bit co);
		fc <= c;
		fd <= d;
		pend_fire = co;
		if (!co)
		begin
			@(posedge hclk);
			fire <= 1'b1;
			@(posedge hclk);
			fire <= 1'b0;
			repeat (2) @(posedge hclk);
		end
	endtask : ev
	initial
	begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		wr(`ADCSF_OFF_CH_ENA, 32'h3);
		rd(`ADCSF_OFF_CH_STAT, 32'h3);
		chk("chan_enable", {24'h0, chan_enable}, 32'h3);
		rd(`ADCSF_OFF_CH_ENA, 32'h0);
		rd(7'h60, 32'h0);
		$display("test registers done");
		ev(3'd0, 10'h155, 0);
		rd(C0, 32'h155);
		rd(ST, 32'h10000);
		rd(LA, 32'h155);
		rd(ST, 32'h0);
		$display("test clear on read done");
		ev(3'd1, 10'h2aa, 0);
		ev(3'd0, 10'h011, 1);
		rd(LA, 32'h12aa);
		rd(ST, 32'h30001);
		ev(3'd5, 10'h3ff, 1);
		rd(LA, 32'h0011);
		rd(ST, 32'h0);
		rd(C0 + 7'h14, 32'h0);
		$display("test last read with result done");
		ev(3'd0, 10'h0aa, 0);
		ev(3'd0, 10'h0bb, 1);
		rd(C0 + 7'h04, 32'h2aa);
		rd(ST, 32'h30101);
		ev(3'd0, 10'h0cc, 0);
		rd(C0, 32'h0cc);
		ev(3'd0, 10'h0dd, 1);
		rd(ST, 32'h30100);
		rd(ST, 32'h30001);
		rd(ST, 32'h10001);
		ev(3'd0, 10'h0ee, 0);
		rd(LA, 32'h00ee);
		ev(3'd1, 10'h3ff, 1);
		rd(ST, 32'h20100);
		rd(ST, 32'h10002);
		$display("test overrun done");
		wr(`ADCSF_OFF_MODE, 32'h1);
		repeat (8) @(posedge hclk);
		chk("low_power", {31'h0, low_power}, 32'h0);
		wr(`ADCSF_OFF_CTRL, 32'h1);
		repeat (8) @(posedge hclk);
		chk("low_power", {31'h0, low_power}, 32'h1);
		wr(`ADCSF_OFF_MODE, 32'h0);
		repeat (2) @(posedge hclk);
		chk("low_power", {31'h0, low_power}, 32'h0);
		$display("test sleep done");
		end_of_test();
	end
endmodule : adcsf_top_tb
